// File: include/uds_params.svh
// Constants of the serial data and status block: addresses, bit positions, reset values, timing.
// Assumes a 12-bit register file address and one fixed character format.
`ifndef UDS_PARAMS_SVH
`define UDS_PARAMS_SVH

`define UDS_ADDR_DATA 12'hf40
`define UDS_ADDR_STATUS 12'hf41

`define UDS_ST_RX_READY 7
`define UDS_ST_PARITY 6
`define UDS_ST_OE 5
`define UDS_ST_FRAMING 4
`define UDS_ST_BRK 3
`define UDS_ST_HOLD_EMPTY 2
`define UDS_ST_SHIFT_IDLE 1
`define UDS_ST_CTS 0

`define UDS_RST_HOLD_EMPTY 1'b1
`define UDS_RST_SHIFT_IDLE 1'b1

`define UDS_BIT_CYCLES 16'h0020
`define UDS_HALF_CYCLES 16'h0010
`define UDS_ODD_PARITY 1'b0
`define UDS_FIFO_DEPTH 8

`endif

// File: include/uds_pkg.sv
// Types shared by the serial data and status block.
// Assumes nothing beyond the header of constants.
package uds_pkg;
	typedef enum logic [2:0] {UDS_TX_IDLE, UDS_TX_START, UDS_TX_DATA, UDS_TX_PAR, UDS_TX_STOP} uds_tx_state_t;
	typedef enum logic [2:0] {UDS_RX_IDLE, UDS_RX_START, UDS_RX_DATA, UDS_RX_PAR, UDS_RX_STOP} uds_rx_state_t;
endpackage

// File: hdl/uds_sync2.sv
// Two-stage synchroniser for one level arriving from outside the clock domain.
// Assumes the level changes no faster than a few clock periods.
`timescale 1ns/1ps
module uds_sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_reg;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			meta_reg <= RESET_VAL;
			o_sync <= RESET_VAL;
		end
		else
		begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule

// File: hdl/uds_fifo.sv
// Small FIFO with valid/ready on both sides; the head word comes out of a register.
// Assumes the drain side pops only while o_out_valid is high.
`timescale 1ns/1ps
module uds_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW-1:0] rd_ptr_next;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign push = i_in_valid && o_in_ready;
	assign pop = i_out_ready && o_out_valid;
	assign rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= (AW+1)'(count_reg + push - pop);
			o_in_ready <= (AW+1)'(count_reg + push - pop) != (AW+1)'(DEPTH);
			o_out_valid <= (AW+1)'(count_reg + push - pop) != '0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= i_in_data;
	end

	// Write-through keeps the head register right when the word just written is the next one out
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			o_out_data <= '0;
		else if (push && wr_ptr_reg == rd_ptr_next)
			o_out_data <= i_in_data;
		else
			o_out_data <= mem[rd_ptr_next];
	end
endmodule

// File: hdl/uds_core.sv
// Serial transceiver data and status registers with their transmitter and receiver.
// Assumes a register file port with one-cycle read and write strobes, and a fixed
// character of start, 8 data bits LSB first, one parity bit and one stop bit.
`timescale 1ns/1ps
`include "uds_params.svh"
module uds_core
	import uds_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [11:0] i_addr,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rdata_valid,
	output logic o_serial_out_pin,
	input wire logic i_serial_in_pin,
	input wire logic i_cts_n
);

////////////////////////////////////////////////////////////////////////////////
	logic rx_s;
	logic cts_s;
	logic wr_data;
	logic rd_data;
	logic rd_status;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;

	uds_sync2 #(.RESET_VAL(1'b1)) u_rx_sync (.i_clk(i_clk), .i_reset(i_reset), .i_async(i_serial_in_pin),
		.o_sync(rx_s));
	uds_sync2 #(.RESET_VAL(1'b1)) u_cts_sync (.i_clk(i_clk), .i_reset(i_reset), .i_async(i_cts_n),
		.o_sync(cts_s));

	assign wr_data = i_wr_en && i_addr == `UDS_ADDR_DATA;
	assign rd_data = i_rd_en && i_addr == `UDS_ADDR_DATA;
	assign rd_status = i_rd_en && i_addr == `UDS_ADDR_STATUS;

	// A write while full would be lost; the ready term blocks it instead of corrupting the queue
	uds_fifo #(.WIDTH(8), .DEPTH(`UDS_FIFO_DEPTH)) u_tx_fifo (
		.i_clk(i_clk), .i_reset(i_reset),
		.i_in_valid(wr_data), .o_in_ready(fifo_in_ready), .i_in_data(i_wdata),
		.o_out_valid(fifo_out_valid), .i_out_ready(fifo_pop), .o_out_data(fifo_out_data));

////////////////////////////////////////////////////////////////////////////////
	uds_tx_state_t tx_state_reg;
	logic [15:0] tx_cnt_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_shift_reg;
	logic tx_par_reg;
	logic tx_bit_end;
	logic tx_holding_empty_reg;
	logic tx_shift_idle_reg;

	assign tx_bit_end = tx_cnt_reg == `UDS_BIT_CYCLES - 16'h0001;
	assign fifo_pop = tx_state_reg == UDS_TX_IDLE && fifo_out_valid;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			tx_state_reg <= UDS_TX_IDLE;
			tx_cnt_reg <= 16'h0000;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_par_reg <= 1'b0;
		end
		else
		begin
			tx_cnt_reg <= (tx_state_reg == UDS_TX_IDLE || tx_bit_end) ? 16'h0000 : 16'(tx_cnt_reg + 16'h0001);
			case (tx_state_reg)
				UDS_TX_IDLE:
					if (fifo_out_valid)
					begin
						tx_shift_reg <= fifo_out_data;
						tx_par_reg <= `UDS_ODD_PARITY ^ (^fifo_out_data);
						tx_state_reg <= UDS_TX_START;
					end
				UDS_TX_START:
					if (tx_bit_end)
					begin
						tx_bit_reg <= 3'h0;
						tx_state_reg <= UDS_TX_DATA;
					end
				UDS_TX_DATA:
					if (tx_bit_end)
					begin
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						tx_bit_reg <= 3'(tx_bit_reg + 3'h1);
						if (tx_bit_reg == 3'h7)
							tx_state_reg <= UDS_TX_PAR;
					end
				UDS_TX_PAR:
					if (tx_bit_end)
						tx_state_reg <= UDS_TX_STOP;
				UDS_TX_STOP:
					if (tx_bit_end)
						tx_state_reg <= UDS_TX_IDLE;
				default:
					tx_state_reg <= UDS_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			o_serial_out_pin <= 1'b1;
		else
			case (tx_state_reg)
				UDS_TX_START: o_serial_out_pin <= 1'b0;
				UDS_TX_DATA: o_serial_out_pin <= tx_shift_reg[0];
				UDS_TX_PAR: o_serial_out_pin <= tx_par_reg;
				default: o_serial_out_pin <= 1'b1;
			endcase
	end

	// The flag rises only at the end of a start bit, and only with room in the queue
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			tx_holding_empty_reg <= `UDS_RST_HOLD_EMPTY;
		else if (wr_data)
			tx_holding_empty_reg <= 1'b0;
		else if (tx_state_reg == UDS_TX_START && tx_bit_end && fifo_in_ready)
			tx_holding_empty_reg <= 1'b1;
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			tx_shift_idle_reg <= `UDS_RST_SHIFT_IDLE;
		else
			tx_shift_idle_reg <= tx_state_reg == UDS_TX_IDLE && !fifo_out_valid && !wr_data;
	end

////////////////////////////////////////////////////////////////////////////////
	uds_rx_state_t rx_state_reg;
	logic [15:0] rx_cnt_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	logic rx_par_bad_reg;
	logic rx_par_zero_reg;
	logic rx_sample;
	logic rx_done;
	logic char_framing;
	logic char_brk;
	logic [7:0] rx_buf_reg;
	logic rx_byte_ready_reg;
	logic parity_error_flag_reg;
	logic oe_reg;
	logic framing_flag_reg;
	logic brk_reg;

	assign rx_sample = rx_cnt_reg == `UDS_BIT_CYCLES - 16'h0001;
	assign rx_done = rx_state_reg == UDS_RX_STOP && rx_sample;
	assign char_framing = !rx_s;
	assign char_brk = !rx_s && rx_par_zero_reg && rx_shift_reg == 8'h00;

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rx_state_reg <= UDS_RX_IDLE;
			rx_cnt_reg <= 16'h0000;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_par_bad_reg <= 1'b0;
			rx_par_zero_reg <= 1'b0;
		end
		else
		begin
			rx_cnt_reg <= (rx_state_reg == UDS_RX_IDLE || rx_sample) ? 16'h0000 : 16'(rx_cnt_reg + 16'h0001);
			case (rx_state_reg)
				UDS_RX_IDLE:
					if (!rx_s)
						rx_state_reg <= UDS_RX_START;
				UDS_RX_START:
					// A glitch shorter than half a bit is not taken as a start bit
					if (rx_cnt_reg == `UDS_HALF_CYCLES - 16'h0001)
					begin
						rx_cnt_reg <= 16'h0000;
						rx_bit_reg <= 3'h0;
						rx_state_reg <= rx_s ? UDS_RX_IDLE : UDS_RX_DATA;
					end
				UDS_RX_DATA:
					if (rx_sample)
					begin
						rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
						rx_bit_reg <= 3'(rx_bit_reg + 3'h1);
						if (rx_bit_reg == 3'h7)
							rx_state_reg <= UDS_RX_PAR;
					end
				UDS_RX_PAR:
					if (rx_sample)
					begin
						rx_par_bad_reg <= rx_s != (`UDS_ODD_PARITY ^ (^rx_shift_reg));
						rx_par_zero_reg <= !rx_s;
						rx_state_reg <= UDS_RX_STOP;
					end
				UDS_RX_STOP:
					if (rx_sample)
						rx_state_reg <= UDS_RX_IDLE;
				default:
					rx_state_reg <= UDS_RX_IDLE;
			endcase
		end
	end

	// A character completing in the cycle of the read is loaded, not counted as overrun
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rx_buf_reg <= 8'h00;
			rx_byte_ready_reg <= 1'b0;
			parity_error_flag_reg <= 1'b0;
			framing_flag_reg <= 1'b0;
			brk_reg <= 1'b0;
		end
		else if (rx_done && (!rx_byte_ready_reg || rd_data))
		begin
			rx_buf_reg <= rx_shift_reg;
			rx_byte_ready_reg <= 1'b1;
			parity_error_flag_reg <= rx_par_bad_reg;
			framing_flag_reg <= char_framing;
			brk_reg <= char_brk;
		end
		else if (rd_data)
		begin
			rx_byte_ready_reg <= 1'b0;
			parity_error_flag_reg <= 1'b0;
			framing_flag_reg <= 1'b0;
			brk_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			oe_reg <= 1'b0;
		else if (rx_done && rx_byte_ready_reg && !rd_data)
			oe_reg <= 1'b1;
		else if (rd_data && !rx_byte_ready_reg)
			oe_reg <= 1'b0;
	end

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_rdata <= 8'h00;
			o_rdata_valid <= 1'b0;
		end
		else
		begin
			o_rdata_valid <= i_rd_en;
			if (rd_data)
				o_rdata <= rx_buf_reg;
			else if (rd_status)
				o_rdata <= {rx_byte_ready_reg, parity_error_flag_reg, oe_reg, framing_flag_reg, brk_reg,
					tx_holding_empty_reg, tx_shift_idle_reg, cts_s};
			else
				o_rdata <= 8'h00;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	tx_line_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
		tx_state_reg == UDS_TX_IDLE |=> o_serial_out_pin)
		else $error("serial output not high while idle");

	data_read_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
		rd_data && !rx_done |=> !rx_byte_ready_reg)
		else $error("receive-ready not cleared by read");

	overrun_keep_a: assert property (@(posedge i_clk) disable iff (i_reset)
		rx_done && rx_byte_ready_reg && !rd_data |=> oe_reg && $stable(rx_buf_reg))
		else $error("overrun lost the unread byte");

	overrun_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		rd_data && rx_byte_ready_reg && oe_reg |=> oe_reg)
		else $error("overrun cleared while byte was unread");

	holding_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_data |=> !tx_holding_empty_reg)
		else $error("holding-empty not cleared by write");

	first_bit_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
		tx_state_reg == UDS_TX_START && tx_bit_end && fifo_in_ready && !wr_data |=> tx_holding_empty_reg)
		else $error("holding-empty not set after first bit");

	shift_busy_a: assert property (@(posedge i_clk) disable iff (i_reset)
		tx_state_reg != UDS_TX_IDLE |=> !tx_shift_idle_reg)
		else $error("shift-idle high while shifting");

	status_cts_a: assert property (@(posedge i_clk) disable iff (i_reset)
		rd_status |=> o_rdata[`UDS_ST_CTS] == $past(cts_s)
			&& o_rdata[`UDS_ST_HOLD_EMPTY] == $past(tx_holding_empty_reg))
		else $error("status read shows wrong level");

	rx_load_a: assert property (@(posedge i_clk) disable iff (i_reset)
		rx_done && !rx_byte_ready_reg |=> rx_byte_ready_reg && rx_buf_reg == $past(rx_shift_reg)
			&& parity_error_flag_reg == $past(rx_par_bad_reg) && framing_flag_reg == $past(char_framing)
			&& brk_reg == $past(char_brk))
		else $error("received character not loaded with flags");
endmodule

// File: verification/uds_remote_model.sv
// Remote serial transceiver: sends frames into the block and decodes the frames that the block sends.
// Assumes 32 clocks a bit, start, 8 data bits LSB first, even parity, one stop bit.
`timescale 1ns/1ps
module uds_remote_model (
	input wire logic i_clk,
	input wire logic i_line,
	output logic o_line
);
	int rx_count = 0;
	logic [7:0] rx_byte;
	logic rx_par;
	logic rx_stop;

	initial o_line = 1'b1;

	////////////////////////////////////////////////////////////////
	// A low stop bit is held only past mid-bit, so it is not taken for a new start
	task automatic send(input logic [7:0] d, input logic par_flip, input logic stop);
		logic [10:0] f;
		f = {stop, (^d) ^ par_flip, d, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge i_clk);
			o_line <= f[i];
			repeat ((i == 10 && !stop) ? 23 : 31) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_line <= 1'b1;
		repeat (8) @(posedge i_clk);
	endtask

	////////////////////////////////////////////////////////////////
	// Samples each bit at its middle, counted from the falling start edge
	initial
	forever
	begin
		@(negedge i_line);
		repeat (16) @(posedge i_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (32) @(posedge i_clk);
			rx_byte[i] = i_line;
		end
		repeat (32) @(posedge i_clk);
		rx_par = i_line;
		repeat (32) @(posedge i_clk);
		rx_stop = i_line;
		rx_count++;
	end
endmodule

// File: verification/tb.sv
// Testbench of the serial data and status block: register calls and serial traffic with expected values.
// Assumes the one-cycle read and write strobes and the fixed 32-clock bit time of the block.
`timescale 1ns/1ps
`include "uds_params.svh"
module tb;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [11:0] i_addr = 12'h000;
	logic i_wr_en = 1'b0;
	logic i_rd_en = 1'b0;
	logic [7:0] i_wdata = 8'h00;
	logic i_cts_n = 1'b1;
	logic [7:0] o_rdata;
	logic o_rdata_valid;
	logic o_serial_out_pin;
	logic i_serial_in_pin;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] rv;
	// Idle status: holding empty, shifter idle, clear-to-send line high
	localparam logic [7:0] IDLE = 8'h07;
	logic [7:0] cd [4] = '{8'h3c, 8'h5a, 8'h81, 8'h00};
	logic cp [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic cs [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	logic [7:0] ce [4] = '{8'h87, 8'hc7, 8'h97, 8'h9f};

	uds_core uds_core_i (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
		.o_serial_out_pin(o_serial_out_pin), .i_serial_in_pin(i_serial_in_pin), .i_cts_n(i_cts_n));
	uds_remote_model uds_remote_model_i (.i_clk(i_clk), .i_line(o_serial_out_pin), .o_line(i_serial_in_pin));

	initial
	forever
		#2.5 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// The whole run needs about 3000 cycles
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr_en <= 1'b1;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
		#1;
		chk8(o_rdata | {7'h00, o_rdata_valid}, 8'h00, "no read answer on write");
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		#1;
		d = o_rdata;
		chk8({7'h00, o_rdata_valid}, 8'h01, "read answer strobe");
	endtask

	task automatic st(input logic [7:0] exp, input string what);
		logic [7:0] s;
		rd(`UDS_ADDR_STATUS, s);
		chk8(s, exp, what);
	endtask

	task automatic tx_chk(input int n, input logic [7:0] d);
		for (int k = 0; k < 1000 && uds_remote_model_i.rx_count < n; k++)
			@(posedge i_clk);
		chk8(8'(uds_remote_model_i.rx_count), 8'(n), "frames seen by remote");
		chk8(uds_remote_model_i.rx_byte, d, "sent byte");
		chk8({6'h00, uds_remote_model_i.rx_par, uds_remote_model_i.rx_stop}, {6'h00, ^d, 1'b1}, "sent frame");
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		st(IDLE, "status after reset");
		@(posedge i_clk);
		i_cts_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		st(8'h06, "clear-to-send low");
		@(posedge i_clk);
		i_cts_n <= 1'b1;
		wr(`UDS_ADDR_STATUS, 8'hff);
		st(IDLE, "status after write to status");
		rd(12'hf42, rv);
		chk8(rv, 8'h00, "unmapped read");
		// Transmit two bytes back to back, the second loaded early
		wr(`UDS_ADDR_DATA, 8'ha5);
		repeat (3) @(posedge i_clk);
		st(8'h01, "status while sending");
		repeat (40) @(posedge i_clk);
		st(8'h05, "holding empty after start bit");
		wr(`UDS_ADDR_DATA, 8'h3c);
		st(8'h01, "holding full again");
		tx_chk(1, 8'ha5);
		tx_chk(2, 8'h3c);
		repeat (40) @(posedge i_clk);
		st(IDLE, "transmitter idle");
		// Good byte, parity error, framing error, break
		for (int i = 0; i < 4; i++)
		begin
			uds_remote_model_i.send(cd[i], cp[i], cs[i]);
			repeat (4) @(posedge i_clk);
			st(ce[i], "status after receive");
			rd(`UDS_ADDR_DATA, rv);
			chk8(rv, cd[i], "received byte");
			st(IDLE, "status after data read");
		end
		// Overrun: second byte arrives while the first is unread
		uds_remote_model_i.send(8'h11, 1'b0, 1'b1);
		uds_remote_model_i.send(8'h22, 1'b0, 1'b1);
		repeat (4) @(posedge i_clk);
		st(8'ha7, "status after overrun");
		rd(`UDS_ADDR_DATA, rv);
		chk8(rv, 8'h11, "byte kept on overrun");
		st(8'h27, "overrun kept after first read");
		rd(`UDS_ADDR_DATA, rv);
		chk8(rv, 8'h11, "dropped byte never loaded");
		st(IDLE, "overrun cleared");
		end_of_test();
	end
endmodule
